// ===== hw/mcfw_pkg.sv
// Package: register map, field layouts and bus carriers of the mailbox channel flag window
package mcfw_pkg;

   // Implemented channels (1 to 124) and window geometry
   localparam int          NUM_CHANNELS   = 4;
   localparam int          MAX_CHANNELS   = 124;
   localparam int          CH_IDX_W       = 7;
   localparam int          WORD_IDX_W     = 3;
   localparam int          ADDR_W         = 13;
   localparam int          DATA_W         = 32;

   // Offsets inside one channel window (eight words each)
   localparam logic [4:0]  OFF_FLAG_STATUS   = 5'h00;
   localparam logic [4:0]  OFF_MASKED_STATUS = 5'h04;
   localparam logic [4:0]  OFF_FLAG_CLEAR    = 5'h08;
   localparam logic [4:0]  OFF_FLAG_SET      = 5'h0c;
   localparam logic [4:0]  OFF_MASK_STATE    = 5'h10;
   localparam logic [4:0]  OFF_MASK_SET      = 5'h14;
   localparam logic [4:0]  OFF_MASK_CLEAR    = 5'h18;

   // Frame bases: receiver view at 0x0000, sender view at 0x1000
   localparam logic [0:0]  FRAME_RECEIVER = 1'h0;
   localparam logic [0:0]  FRAME_SENDER   = 1'h1;
   localparam int          FRAME_BIT      = 12;

   // Summary registers in the receiver frame
   localparam logic [11:0] OFF_IRQ_STATUS = 12'hf90;
   localparam logic [11:0] OFF_IRQ_MASK   = 12'hf98;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Decoded access to one channel window
   typedef struct packed {
      logic                    hit;
      logic [0:0]              frame;
      logic [CH_IDX_W-1:0]     channel;
      logic [4:0]              offset;
   } mcfw_decode_t;

   // AXI4-Lite request and answer groups
   typedef struct packed {
      logic                awvalid;
      logic [ADDR_W-1:0]   awaddr;
      logic                wvalid;
      logic [DATA_W-1:0]   wdata;
      logic [3:0]          wstrb;
      logic                bready;
      logic                arvalid;
      logic [ADDR_W-1:0]   araddr;
      logic                rready;
   } mcfw_axi_req_t;

   typedef struct packed {
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [DATA_W-1:0]   rdata;
      logic [1:0]          rresp;
   } mcfw_axi_rsp_t;

endpackage

// ===== hw/mcfw_channel_window.sv
// Module: mailbox channel flag window with AXI4-Lite slave and channel interrupts
//
// Behaviour
// - Each channel holds a 32-bit flag status word, reset to zero, read-only.
// - Writing one to a flag-set bit sets the matching status bit.
// - Writing one to a flag-clear bit clears the status and masked status bit.
// - Setting a set bit or clearing a clear bit changes nothing else.
// - Simultaneous set and clear of one bit leaves the bit set.
// - Zero bits written to flag-set leave the status unchanged.
// - Zero bits written to flag-clear leave the status unchanged.
// - Flag-set and flag-clear registers read as zero.
// - Masked status equals status where mask is zero, zero where mask is one.
// - Channel interrupt is high exactly while masked status is nonzero.
// - Masked status read reflects status and mask at the moment of the read.
// - The 32-bit mask resets to zero and is readable by the receiver.
// - Flag-set lives only in the sender view; the others in the receiver view.
// - Mask-set ones set mask bits; zeros do nothing; reads return zero.
// - Mask-clear ones clear mask bits; zeros do nothing; reads return zero.
// - One to 124 channels of eight words; absent channels read zero, ignore writes.
// - Receiver reset clears the flag status the sender sees as well.
`timescale 1ns/1ps

module mcfw_channel_window
   import mcfw_pkg::*;
(
   input  wire logic                        sys_clk,
   input  wire logic                        srst,
   input  wire mcfw_pkg::mcfw_axi_req_t     axiReq,
   output      mcfw_pkg::mcfw_axi_rsp_t     axiRsp,
   output      logic [mcfw_pkg::NUM_CHANNELS-1:0] channelIrq,
   output      logic                        irq
);
   import mcfw_pkg::*;

   // Address decode shared by the write and read paths
   function automatic mcfw_decode_t decodeAddr(input logic [ADDR_W-1:0] addr);
      mcfw_decode_t d;
      d.frame   = addr[FRAME_BIT];
      d.channel = addr[FRAME_BIT-1 -: CH_IDX_W];
      d.offset  = addr[4:0];
      d.hit     = (32'(d.channel) < NUM_CHANNELS);
      return d;
   endfunction

   // Per-channel state
   logic [DATA_W-1:0]       flagStatus_reg [NUM_CHANNELS];
   logic [DATA_W-1:0]       maskState_reg  [NUM_CHANNELS];
   logic [DATA_W-1:0]       maskedStatus   [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] irqStatus_reg;
   logic [NUM_CHANNELS-1:0] irqMask_reg;

   // Write and read channel capture registers
   logic                    awHeld_reg;
   logic                    wHeld_reg;
   logic [ADDR_W-1:0]       awAddr_reg;
   logic [DATA_W-1:0]       wData_reg;
   logic [3:0]              wStrb_reg;
   logic                    bValid_reg;
   logic                    arValid_reg;
   logic                    rValid_reg;
   logic [DATA_W-1:0]       rData_reg;

   // Write commit strobes
   logic                    writeFire;
   logic                    fullWord;
   mcfw_decode_t            wDec;
   mcfw_decode_t            rDec;
   logic [NUM_CHANNELS-1:0] chanPrev;
   logic [NUM_CHANNELS-1:0] chanPrevLvl_reg;

   // Masked status and channel interrupt, purely combinational so reads never lag
   genvar g;
   generate
      for (g = 0; g < NUM_CHANNELS; g++)
      begin : gMask
         assign maskedStatus[g] = flagStatus_reg[g] & ~maskState_reg[g];
         assign channelIrq[g]   = |maskedStatus[g];
         assign chanPrev[g]     = irqStatus_reg[g];
      end
   endgenerate

   // Aggregate interrupt: sticky per-channel events gated by the mask
   assign irq = |(irqStatus_reg & irqMask_reg);

   // Write address and data are taken independently, in either order
   assign axiRsp.awready = ~awHeld_reg & ~bValid_reg;
   assign axiRsp.wready  = ~wHeld_reg & ~bValid_reg;
   assign axiRsp.bvalid  = bValid_reg;
   assign axiRsp.bresp   = RESP_OKAY;
   assign axiRsp.arready = ~arValid_reg & ~rValid_reg;
   assign axiRsp.rvalid  = rValid_reg;
   assign axiRsp.rdata   = rData_reg;
   assign axiRsp.rresp   = RESP_OKAY;

   assign writeFire = awHeld_reg & wHeld_reg & ~bValid_reg;
   assign fullWord  = &wStrb_reg; // partial writes are dropped
   assign wDec      = decodeAddr(awAddr_reg);

   // Capture of write address
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         awHeld_reg <= 1'b0;
         awAddr_reg <= '0;
      end
      else if (axiReq.awvalid && axiRsp.awready)
      begin
         awHeld_reg <= 1'b1;
         awAddr_reg <= axiReq.awaddr;
      end
      else if (writeFire)
         awHeld_reg <= 1'b0;
   end

   // Capture of write data
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         wHeld_reg <= 1'b0;
         wData_reg <= '0;
         wStrb_reg <= '0;
      end
      else if (axiReq.wvalid && axiRsp.wready)
      begin
         wHeld_reg <= 1'b1;
         wData_reg <= axiReq.wdata;
         wStrb_reg <= axiReq.wstrb;
      end
      else if (writeFire)
         wHeld_reg <= 1'b0;
   end

   // Write response one cycle after both halves are in; unmapped writes still answer OKAY
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         bValid_reg <= 1'b0;
      else if (writeFire)
         bValid_reg <= 1'b1;
      else if (axiReq.bready)
         bValid_reg <= 1'b0;
   end

   // Flag status and mask per channel; set is applied after clear so set wins
   generate
      for (g = 0; g < NUM_CHANNELS; g++)
      begin : gChan
         logic sel;
         logic rxWin;
         logic txWin;
         assign sel   = writeFire && fullWord && wDec.hit
                        && (32'(wDec.channel) == g);
         assign rxWin = sel && (wDec.frame == FRAME_RECEIVER);
         assign txWin = sel && (wDec.frame == FRAME_SENDER);

         always_ff @(posedge sys_clk)
         begin
            if (srst)
               flagStatus_reg[g] <= RESET_WORD;
            else
            begin
               logic [DATA_W-1:0] clr;
               logic [DATA_W-1:0] set;
               clr = (rxWin && wDec.offset == OFF_FLAG_CLEAR) ? wData_reg : '0;
               set = (txWin && wDec.offset == OFF_FLAG_SET) ? wData_reg : '0;
               flagStatus_reg[g] <= (flagStatus_reg[g] & ~clr) | set;
            end
         end

         always_ff @(posedge sys_clk)
         begin
            if (srst)
               maskState_reg[g] <= RESET_WORD;
            else
            begin
               logic [DATA_W-1:0] mclr;
               logic [DATA_W-1:0] mset;
               mclr = (rxWin && wDec.offset == OFF_MASK_CLEAR) ? wData_reg : '0;
               mset = (rxWin && wDec.offset == OFF_MASK_SET) ? wData_reg : '0;
               maskState_reg[g] <= (maskState_reg[g] & ~mclr) | mset;
            end
         end
      end
   endgenerate

   // Sticky event on each rising channel interrupt; write-one-to-clear, set wins
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         irqStatus_reg <= '0;
      else
      begin
         logic [NUM_CHANNELS-1:0] clrBits;
         logic [NUM_CHANNELS-1:0] rise;
         clrBits = '0;
         if (writeFire && fullWord && wDec.frame == FRAME_RECEIVER
             && awAddr_reg[FRAME_BIT-1:0] == OFF_IRQ_STATUS)
            clrBits = wData_reg[NUM_CHANNELS-1:0];
         rise = channelIrq & ~chanPrevLvl_reg;
         irqStatus_reg <= (chanPrev & ~clrBits) | rise;
      end
   end

   // Previous channel interrupt level for edge detection; resets to the idle low level
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         chanPrevLvl_reg <= '0;
      else
         chanPrevLvl_reg <= channelIrq;
   end

   // Interrupt mask register, plain read-write
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         irqMask_reg <= '0;
      else if (writeFire && fullWord && wDec.frame == FRAME_RECEIVER
               && awAddr_reg[FRAME_BIT-1:0] == OFF_IRQ_MASK)
         irqMask_reg <= wData_reg[NUM_CHANNELS-1:0];
   end

   // Read path: address taken, data registered next cycle
   assign rDec = decodeAddr(axiReq.araddr);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         arValid_reg <= 1'b0;
         rValid_reg  <= 1'b0;
         rData_reg   <= RESET_WORD;
      end
      else if (axiReq.arvalid && axiRsp.arready)
      begin
         rValid_reg <= 1'b1;
         rData_reg  <= readWord(axiReq.araddr, rDec);
      end
      else if (rValid_reg && axiReq.rready)
         rValid_reg <= 1'b0;
   end

   // Read multiplexer; write-only and reserved words read zero
   function automatic logic [DATA_W-1:0] readWord(input logic [ADDR_W-1:0] addr,
                                                  input mcfw_decode_t d);
      logic [DATA_W-1:0] v;
      v = RESET_WORD;
      if (d.frame == FRAME_RECEIVER && addr[FRAME_BIT-1:0] == OFF_IRQ_STATUS)
         v = DATA_W'(irqStatus_reg);
      else if (d.frame == FRAME_RECEIVER && addr[FRAME_BIT-1:0] == OFF_IRQ_MASK)
         v = DATA_W'(irqMask_reg);
      else if (d.hit)
      begin
         for (int i = 0; i < NUM_CHANNELS; i++)
         begin
            if (32'(d.channel) == i)
            begin
               if (d.offset == OFF_FLAG_STATUS)
                  v = flagStatus_reg[i];
               else if (d.frame == FRAME_RECEIVER && d.offset == OFF_MASKED_STATUS)
                  v = maskedStatus[i];
               else if (d.frame == FRAME_RECEIVER && d.offset == OFF_MASK_STATE)
                  v = maskState_reg[i];
            end
         end
      end
      return v;
   endfunction

endmodule

// ===== test/mcfw_channel_window_asserts.sv
// Checker: bus answer timing and read-back relations of the flag window
`timescale 1ns/1ps
module mcfw_channel_window_asserts
   import mcfw_pkg::*;
(
   input wire logic                              sys_clk,
   input wire logic                              srst,
   input wire mcfw_pkg::mcfw_axi_req_t           axiReq,
   input wire mcfw_pkg::mcfw_axi_rsp_t           axiRsp,
   input wire logic [mcfw_pkg::NUM_CHANNELS-1:0] channelIrq,
   input wire logic                              irq
);
   import mcfw_pkg::*;
   logic [ADDR_W-1:0]       rdAddr_reg;
   logic [NUM_CHANNELS-1:0] rdIrq_reg;
   logic                    woRd;
   logic                    absRd;
   logic                    mskRd;
   logic                    wrBoth;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Read address and interrupts as they stood when the read was taken
   always_ff @(posedge sys_clk)
   begin
      if (axiReq.arvalid && axiRsp.arready)
      begin
         rdAddr_reg <= axiReq.araddr;
         rdIrq_reg <= channelIrq;
      end
   end
   // Kinds of read in flight
   assign woRd = rdAddr_reg[11:0] < 12'hf80 && rdAddr_reg[4:0] inside {5'h08, 5'h0c, 5'h14, 5'h18};
   assign absRd = !rdAddr_reg[12] && rdAddr_reg[11:5] >= NUM_CHANNELS && rdAddr_reg < 13'hf80;
   assign mskRd = rdAddr_reg[12:5] < NUM_CHANNELS && rdAddr_reg[4:0] == OFF_MASKED_STATUS;
   assign wrBoth = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
   a_reset_clean: assert property ($fell(srst) |-> channelIrq == '0 && !irq && !axiRsp.bvalid)
      else $error("state not clear after reset");
   a_write_answer: assert property (wrBoth |=> ##1 axiRsp.bvalid && axiRsp.bresp == RESP_OKAY)
      else $error("write not answered next cycle");
   a_busy_refuse: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
      else $error("write taken while response pending");
   a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid ##1 !axiRsp.rvalid)
      else $error("read answer timing wrong");
   a_wo_zero: assert property ($rose(axiRsp.rvalid) && woRd |-> axiRsp.rdata == '0)
      else $error("write-only word read nonzero");
   a_absent_zero: assert property ($rose(axiRsp.rvalid) && absRd |-> axiRsp.rdata == '0)
      else $error("absent channel read nonzero");
   a_masked_irq: assert property ($rose(axiRsp.rvalid) && mskRd |-> (|axiRsp.rdata) == rdIrq_reg[rdAddr_reg[6:5]])
      else $error("channel interrupt disagrees with masked status");
   a_clear_drop: assert property (wrBoth && axiReq.awaddr == 13'h0028 && axiReq.wdata == '1 |=> ##1 !channelIrq[1])
      else $error("interrupt still high after full clear");
endmodule
bind mcfw_channel_window mcfw_channel_window_asserts u_asserts (.sys_clk(sys_clk), .srst(srst),
   .axiReq(axiReq), .axiRsp(axiRsp), .channelIrq(channelIrq), .irq(irq));

// ===== test/mcfw_host_model.sv
// Partner model: bus master standing for the sender and receiver cores
`timescale 1ns/1ps
module mcfw_host_model
   import mcfw_pkg::*;
(
   input  wire logic                    sys_clk,
   output      mcfw_pkg::mcfw_axi_req_t axiReq,
   input  wire mcfw_pkg::mcfw_axi_rsp_t axiRsp
);
   int stuck = 0;
   initial axiReq = '0;
   // One whole-word write; released lines show inverted values, not the old ones
   task automatic wr(logic [12:0] a, logic [31:0] d);
      logic aw = 1'b0;
      logic wd = 1'b0;
      logic b = 1'b0;
      @(posedge sys_clk);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= d;
      axiReq.wstrb <= 4'hf;
      axiReq.bready <= 1'b1;
      for (int n = 0; n < 50 && !b; n++)
      begin
         @(posedge sys_clk);
         if (axiRsp.bvalid)
         begin
            b = 1'b1;
            axiReq.bready <= 1'b0;
         end
         if (!aw && axiRsp.awready)
         begin
            aw = 1'b1;
            axiReq.awvalid <= 1'b0;
            axiReq.awaddr <= ~a;
         end
         if (!wd && axiRsp.wready)
         begin
            wd = 1'b1;
            axiReq.wvalid <= 1'b0;
            axiReq.wdata <= ~d;
         end
      end
      stuck += !b;
   endtask
   // One read; data taken at the edge that shows rvalid
   task automatic rd(logic [12:0] a, output logic [31:0] d);
      logic ar = 1'b0;
      logic r = 1'b0;
      d = '0;
      @(posedge sys_clk);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      axiReq.rready <= 1'b1;
      for (int n = 0; n < 50 && !r; n++)
      begin
         @(posedge sys_clk);
         if (ar && axiRsp.rvalid)
         begin
            r = 1'b1;
            d = axiRsp.rdata;
            axiReq.rready <= 1'b0;
         end
         if (!ar && axiRsp.arready)
         begin
            ar = 1'b1;
            axiReq.arvalid <= 1'b0;
            axiReq.araddr <= ~a;
         end
      end
      stuck += !r;
   endtask
endmodule

// ===== test/testbench.sv
// Testbench: scenarios for the mailbox channel flag window
`timescale 1ns/1ps
module testbench;
   import mcfw_pkg::*;
   logic                    sys_clk = 1'b0;
   logic                    srst = 1'b1;
   mcfw_axi_req_t           axiReq;
   mcfw_axi_rsp_t           axiRsp;
   logic [NUM_CHANNELS-1:0] channelIrq;
   logic                    irq;
   int                      bad_count = 0;
   int                      total_checks = 0;
   logic [31:0]             v;
   always #20 sys_clk = ~sys_clk;
   mcfw_channel_window u_mcfw_channel_window (.sys_clk(sys_clk), .srst(srst), .axiReq(axiReq),
      .axiRsp(axiRsp), .channelIrq(channelIrq), .irq(irq));
   mcfw_host_model u_mcfw_host_model (.sys_clk(sys_clk), .axiReq(axiReq), .axiRsp(axiRsp));
   // Word compare; single-bit results are zero-extended
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic w(logic [12:0] a, logic [31:0] d);
      u_mcfw_host_model.wr(a, d);
   endtask
   task automatic rc(logic [12:0] a, logic [31:0] e);
      u_mcfw_host_model.rd(a, v);
      chk($sformatf("word %h", a), e, v);
   endtask
   task automatic do_reset();
      srst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
   endtask
   // Set and clear through both views, repeats and zero bits included
   task automatic t_flags();
      rc(13'h0020, 32'h0);
      rc(13'h0030, 32'h0);
      w(13'h102c, 32'ha5a5_0001);
      w(13'h102c, 32'h0000_0003);
      rc(13'h0020, 32'ha5a5_0003);
      rc(13'h1020, 32'ha5a5_0003);
      w(13'h0028, 32'h0000_0101);
      w(13'h0028, 32'h0000_0100);
      w(13'h002c, 32'hffff_ffff);
      w(13'h1028, 32'hffff_ffff);
      rc(13'h0020, 32'ha5a5_0002);
      rc(13'h0028, 32'h0);
      rc(13'h102c, 32'h0);
   endtask
   // Mask set and clear against the masked view and channel interrupt
   task automatic t_mask();
      w(13'h0034, 32'hffff_0000);
      rc(13'h0030, 32'hffff_0000);
      rc(13'h0024, 32'h0000_0002);
      chk("chan irq", 32'h1, {31'h0, channelIrq[1]});
      w(13'h0034, 32'h0000_0002);
      chk("chan irq", 32'h0, {31'h0, channelIrq[1]});
      w(13'h0038, 32'hffff_0002);
      rc(13'h0030, 32'h0);
      rc(13'h0024, 32'ha5a5_0002);
      rc(13'h0034, 32'h0);
      rc(13'h0038, 32'h0);
      w(13'h0028, 32'hffff_ffff);
      chk("chan irq", 32'h0, {31'h0, channelIrq[1]});
   endtask
   // Sticky summary: raised while disabled, enabled, cleared
   task automatic t_irq();
      rc(13'h0f90, 32'h0000_0002);
      chk("irq", 32'h0, {31'h0, irq});
      w(13'h0f98, 32'h0000_0002);
      chk("irq", 32'h1, {31'h0, irq});
      w(13'h0f90, 32'h0000_0002);
      chk("irq", 32'h0, {31'h0, irq});
      w(13'h104c, 32'h8000_0000);
      chk("irq", 32'h0, {31'h0, irq});
      rc(13'h0f90, 32'h0000_0004);
   endtask
   // Absent channel, unmapped word, then reset seen from the sender view
   task automatic t_edge();
      w(13'h10ac, 32'hffff_ffff);
      rc(13'h00a0, 32'h0);
      rc(13'h0ffc, 32'h0);
      w(13'h106c, 32'h0000_0001);
      rc(13'h1060, 32'h0000_0001);
      do_reset();
      rc(13'h1060, 32'h0);
      rc(13'h0f98, 32'h0);
   endtask
   task automatic test_done();
      bad_count += u_mcfw_host_model.stuck;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      do_reset();
      t_flags();
      t_mask();
      t_irq();
      t_edge();
      test_done();
   end
endmodule
